// [rtl/spis_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module spis_fifo #(
	parameter int W = 8,
	parameter int D = 32,
	parameter int AW = 5
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_clr,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic [W-1:0] dout;
		logic dv;
	} spis_fifo_st_t;
	spis_fifo_st_t s_r, s_nxt;
	logic [W-1:0] mem_r [D];
	logic push, pop;

	// Handshakes; the output word sits in a register stage that counts toward the depth,
	// so the buffer never holds more than D words in all.
	assign o_in_ready = ((s_r.cnt + (AW+1)'(s_r.dv)) != (AW+1)'(D));
	assign push = i_in_valid && o_in_ready;
	assign o_out_valid = s_r.dv;
	assign o_out_data = s_r.dout;
	assign pop = (s_r.cnt != '0) && (!s_r.dv || i_out_ready);

	// Pointer and output register update.
	always_comb
	begin
		s_nxt = s_r;
		if (s_r.dv && i_out_ready)
			s_nxt.dv = 1'b0;
		if (pop)
		begin
			s_nxt.dout = mem_r[s_r.rp];
			s_nxt.dv = 1'b1;
			s_nxt.rp = s_r.rp + 1'b1;
		end
		if (push)
			s_nxt.wp = s_r.wp + 1'b1;
		s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (i_clr)
			s_nxt = '0;
	end

	// State register.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// Storage array carries no reset; only pointers say what is valid.
	always_ff @(posedge i_clk_sys)
	begin
		if (push)
			mem_r[s_r.wp] <= i_in_data;
	end
endmodule
`default_nettype wire

// [rtl/spis_pkg.sv]
package spis_pkg;
	// Register indices; each register takes one aligned word, at four times its index.
	localparam logic [15:0] SPIS_TX_IDX = 16'h1054;
	localparam logic [15:0] SPIS_RX_IDX = 16'h1055;
	localparam logic [15:0] SPIS_CTL_IDX = 16'h1056;
	localparam logic [15:0] SPIS_TXDATA_IDX = 16'h1057;
	localparam logic [15:0] SPIS_RXDATA_IDX = 16'h1058;
	// Register byte addresses on APB.
	localparam logic [15:0] SPIS_TX_ADDR = {SPIS_TX_IDX[13:0], 2'b00};
	localparam logic [15:0] SPIS_RX_ADDR = {SPIS_RX_IDX[13:0], 2'b00};
	localparam logic [15:0] SPIS_CTL_ADDR = {SPIS_CTL_IDX[13:0], 2'b00};
	localparam logic [15:0] SPIS_TXDATA_ADDR = {SPIS_TXDATA_IDX[13:0], 2'b00};
	localparam logic [15:0] SPIS_RXDATA_ADDR = {SPIS_RXDATA_IDX[13:0], 2'b00};
	// Field positions.
	localparam int SPIS_TX_IE_BIT = 0;
	localparam int SPIS_TX_EMPTY_BIT = 6;
	localparam int SPIS_TX_RDY_BIT = 7;
	localparam int SPIS_CTL_SRST_BIT = 0;
	// Reset values.
	localparam logic SPIS_TX_RDY_RST = 1'b1;
	localparam logic SPIS_TX_EMPTY_RST = 1'b1;
	localparam logic SPIS_IE_RST = 1'b0;
	localparam logic SPIS_SRST_RST = 1'b0;
	// Transmit FIFO shape.
	localparam int SPIS_FIFO_W = 8;
	localparam int SPIS_FIFO_D = 32;
	localparam int SPIS_FIFO_AW = 5;
	typedef enum logic [0:0] {SPIS_TX_IDLE, SPIS_TX_BUSY} spis_txst_t;
endpackage

// [rtl/spis_top.sv]
// Overview of operation
// - Transmit flags update per character: ready when the shifter takes it, empty once it is fully shifted out.
// - Transmit interrupt enable bit 0, resets 0, gates only the request.
// - Buffer-ready bit 7 sets while the holding FIFO has room, clears when a write fills it.
// - Transmit interrupt requested while buffer-ready set and enable is 1.
// - Buffer-ready is read-only and forced 1 by soft or system reset.
// - Transmitter-empty bit 6 is 1 when the FIFO output stage and the shifter are empty.
// - Transmitter-empty is forced 1 by soft or system reset.
// - Transmit register bits one to five are reserved, read undefined.
// - Receive flags update per received character, clear on buffer read.
// - Receive register: enable bit 0 plus seven read-only flags, reset 0.
// - Receive enable gates only char-ready and break requests, not flags.
// - Overrun sets when a new character overwrites an unread one.
`timescale 1ns/100ps
`default_nettype none
module spis_top (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [15:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_shift_valid,
	output logic [spis_pkg::SPIS_FIFO_W-1:0] o_shift_data,
	input wire logic i_shift_ready,
	input wire logic i_shift_done,
	input wire logic i_rx_char_valid,
	input wire logic [7:0] i_rx_char_data,
	input wire logic i_rx_break,
	input wire logic i_rx_framing,
	input wire logic i_rx_parity,
	input wire logic i_rx_wakeup,
	output logic o_tx_irq_req,
	output logic o_rx_irq_req
);
	import spis_pkg::*;

	typedef struct packed {
		logic tx_ie;
		logic rx_ie;
		logic srst_n;
		spis_txst_t txst;
		logic [7:0] rx_holding_buffer;
		logic rx_rdy;
		logic brk;
		logic fe;
		logic oe;
		logic pe;
		logic wake;
		logic [31:0] prdata;
	} spis_st_t;
	spis_st_t s_r, s_nxt;

	logic wr_en, rd_en, rd_setup, addr_ok, soft_rst;
	logic fifo_in_ready, fifo_out_valid, tx_push, tx_rdy, tx_empty;
	logic [7:0] tx_reg;

	// Single-cycle access phase; an unmapped address answers with pslverr.
	function automatic logic spis_hit(input logic [15:0] a);
		spis_hit = (a == SPIS_TX_ADDR) || (a == SPIS_RX_ADDR) || (a == SPIS_CTL_ADDR)
			|| (a == SPIS_TXDATA_ADDR) || (a == SPIS_RXDATA_ADDR);
	endfunction

	// Receive register image: summary, ready, break, framing, overrun, parity, wake, enable.
	function automatic logic [7:0] spis_rx_pack(input spis_st_t st);
		spis_rx_pack = {st.brk || st.fe || st.oe || st.pe, st.rx_rdy, st.brk, st.fe,
			st.oe, st.pe, st.wake, st.rx_ie};
	endfunction

	assign addr_ok = spis_hit(i_paddr);
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !addr_ok;
	assign wr_en = i_psel && i_penable && i_pwrite && addr_ok;
	assign rd_en = i_psel && i_penable && !i_pwrite && addr_ok;
	assign rd_setup = i_psel && !i_penable && !i_pwrite;
	assign soft_rst = !s_r.srst_n;
	assign o_prdata = s_r.prdata;

	// Writes to the data word feed the holding FIFO; a write while it is full is dropped.
	assign tx_push = wr_en && (i_paddr == SPIS_TXDATA_ADDR) && fifo_in_ready && !soft_rst;

	spis_fifo #(
		.W(SPIS_FIFO_W),
		.D(SPIS_FIFO_D),
		.AW(SPIS_FIFO_AW)
	) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_clr(soft_rst),
		.i_in_valid(tx_push),
		.o_in_ready(fifo_in_ready),
		.i_in_data(i_pwdata[7:0]),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(i_shift_ready && !soft_rst),
		.o_out_data(o_shift_data)
	);
	assign o_shift_valid = fifo_out_valid && !soft_rst;

	// Ready follows buffer space; a held soft reset forces the flag high.
	assign tx_rdy = soft_rst || fifo_in_ready;
	// Empty needs no word in the FIFO output stage and no character still on the shifter.
	assign tx_empty = soft_rst || (!fifo_out_valid && (s_r.txst == SPIS_TX_IDLE));
	// The request is gated by the enable; the flag itself is not.
	assign o_tx_irq_req = tx_rdy && s_r.tx_ie;
	assign o_rx_irq_req = s_r.rx_ie && (s_r.rx_rdy || s_r.brk);

	// Reserved bits 1..5 return zero here, but nobody may count on that.
	assign tx_reg = {tx_rdy, tx_empty, 5'h00, s_r.tx_ie};

	// Next-state logic for control, shifter tracking and receive flags.
	always_comb
	begin
		s_nxt = s_r;
		if (wr_en && i_paddr == SPIS_TX_ADDR)
			s_nxt.tx_ie = i_pwdata[SPIS_TX_IE_BIT];
		if (wr_en && i_paddr == SPIS_RX_ADDR)
			s_nxt.rx_ie = i_pwdata[0];
		if (wr_en && i_paddr == SPIS_CTL_ADDR)
			s_nxt.srst_n = i_pwdata[SPIS_CTL_SRST_BIT];
		// Shifter is busy from hand-off until the line reports the last bit out.
		unique case (s_r.txst)
			SPIS_TX_IDLE:
				if (o_shift_valid && i_shift_ready)
					s_nxt.txst = SPIS_TX_BUSY;
			SPIS_TX_BUSY:
				if (i_shift_done)
					s_nxt.txst = (o_shift_valid && i_shift_ready) ? SPIS_TX_BUSY
						: SPIS_TX_IDLE;
		endcase
		// Reading the buffer clears flags; an arriving character wins the same cycle.
		if (rd_en && i_paddr == SPIS_RXDATA_ADDR)
		begin
			s_nxt.rx_rdy = 1'b0;
			s_nxt.brk = 1'b0;
			s_nxt.fe = 1'b0;
			s_nxt.oe = 1'b0;
			s_nxt.pe = 1'b0;
			s_nxt.wake = 1'b0;
		end
		if (i_rx_char_valid)
		begin
			s_nxt.oe = s_r.rx_rdy && !(rd_en && i_paddr == SPIS_RXDATA_ADDR);
			s_nxt.rx_holding_buffer = i_rx_char_data;
			s_nxt.rx_rdy = 1'b1;
			s_nxt.brk = i_rx_break;
			s_nxt.fe = i_rx_framing;
			s_nxt.pe = i_rx_parity;
			s_nxt.wake = i_rx_wakeup;
		end
		// Soft reset freezes the operating flags at their reset values.
		if (soft_rst)
		begin
			s_nxt.txst = SPIS_TX_IDLE;
			s_nxt.rx_rdy = 1'b0;
			s_nxt.brk = 1'b0;
			s_nxt.fe = 1'b0;
			s_nxt.oe = 1'b0;
			s_nxt.pe = 1'b0;
			s_nxt.wake = 1'b0;
		end
		// Read data is loaded at the setup edge, so it already stands when the access
		// edge samples it with pready. Receive values come from the next state, so a
		// character landing on the setup edge is shown rather than lost by the clear.
		if (rd_setup)
		begin
			s_nxt.prdata = 32'h0000_0000;
			if (i_paddr == SPIS_TX_ADDR)
				s_nxt.prdata = {24'h000000, tx_reg};
			else if (i_paddr == SPIS_RX_ADDR)
				s_nxt.prdata = {24'h000000, spis_rx_pack(s_nxt)};
			else if (i_paddr == SPIS_CTL_ADDR)
				s_nxt.prdata = {31'h00000000, s_r.srst_n};
			else if (i_paddr == SPIS_RXDATA_ADDR)
				s_nxt.prdata = {24'h000000, s_nxt.rx_holding_buffer};
		end
	end

	// State register with asynchronous system reset.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s_r <= '0;
			s_r.tx_ie <= SPIS_IE_RST;
			s_r.rx_ie <= SPIS_IE_RST;
			s_r.srst_n <= SPIS_SRST_RST;
			s_r.txst <= SPIS_TX_IDLE;
		end
		else
			s_r <= s_nxt;
	end
endmodule
`default_nettype wire

// [test/spis_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
// Pin-level checks of the status block, all on the system clock.
module spis_monitor (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [15:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_shift_valid,
	input wire logic [spis_pkg::SPIS_FIFO_W-1:0] o_shift_data,
	input wire logic i_shift_ready,
	input wire logic i_rx_char_valid,
	input wire logic o_tx_irq_req,
	input wire logic o_rx_irq_req
);
	import spis_pkg::*;
	logic acc;
	logic hit;
	// Decode kept apart so every check agrees on what is mapped.
	assign acc = i_psel && i_penable;
	assign hit = i_paddr inside {SPIS_TX_ADDR, SPIS_RX_ADDR, SPIS_CTL_ADDR,
		SPIS_TXDATA_ADDR, SPIS_RXDATA_ADDR};
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	property p_rdy; acc |-> o_pready; endproperty
	a_rdy: assert property (p_rdy) else $error("No ready in access");
	property p_err; o_pslverr |-> acc && !hit; endproperty
	a_err: assert property (p_err) else $error("Stray error");
	property p_unm; acc && !hit |-> o_pslverr; endproperty
	a_unm: assert property (p_unm) else $error("Unmapped not refused");
	property p_zero; acc && !i_pwrite && !hit |-> o_prdata == 32'h0; endproperty
	a_zero: assert property (p_zero) else $error("Unmapped read data");
	// A soft reset written at this edge may legally drop the waiting character.
	property p_hold; o_shift_valid && !i_shift_ready
		&& !(acc && i_pwrite && i_paddr == SPIS_CTL_ADDR && !i_pwdata[SPIS_CTL_SRST_BIT])
		|=> o_shift_valid && $stable(o_shift_data);
	endproperty
	a_hold: assert property (p_hold) else $error("Char dropped");
	property p_rst; $rose(i_rst_n) |-> !o_tx_irq_req && !o_rx_irq_req; endproperty
	a_rst: assert property (p_rst) else $error("Irq after reset");
	property p_clr; acc && !i_pwrite && i_paddr == SPIS_RXDATA_ADDR && !i_rx_char_valid
		|=> !o_rx_irq_req; endproperty
	a_clr: assert property (p_clr) else $error("Rx irq kept");
	property p_set; $rose(o_rx_irq_req) |-> $past(i_rx_char_valid) || $past(acc && i_pwrite);
	endproperty
	a_set: assert property (p_set) else $error("Rx irq cause");
endmodule
bind spis_top spis_monitor i_mon (.*);
`default_nettype wire

// [test/spis_shifter_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Line-side shifter: takes one char when free and reports it sent later.
module spis_shifter_model (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_stall,
	input wire logic i_valid,
	input wire logic [7:0] i_data,
	output logic o_ready,
	output logic o_done,
	output logic [7:0] o_last,
	output logic [7:0] o_count
);
	logic [2:0] t;
	assign o_ready = !i_stall && t == 3'h0;
	// The countdown stands for the frame time, so one char is in flight at most.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
		if (!i_rst_n)
		begin
			t <= 3'h0;
			o_done <= 1'b0;
			o_count <= 8'h0;
			o_last <= 8'h0;
		end
		else
		begin
			o_done <= t == 3'h1;
			if (t != 3'h0)
				t <= t - 3'h1;
			else if (i_valid && o_ready)
				t <= 3'h6;
			if (i_valid && o_ready)
				o_last <= i_data;
			if (t == 3'h1)
				o_count <= o_count + 8'h1;
		end
endmodule
`default_nettype wire

// [test/spis_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module spis_top_tb;
	import spis_pkg::*;
	logic i_clk_sys = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, stall = 1;
	logic [15:0] i_paddr = '0;
	logic [31:0] i_pwdata = '0, o_prdata, rd;
	logic o_pready, o_pslverr, o_shift_valid, i_shift_ready, i_shift_done;
	logic o_tx_irq_req, o_rx_irq_req, i_rx_char_valid = 0;
	logic i_rx_break = 0, i_rx_framing = 0, i_rx_parity = 0, i_rx_wakeup = 0;
	logic [7:0] o_shift_data, i_rx_char_data = '0, last, cnt;
	logic [7:0] ex [4] = '{8'h42, 8'hc4, 8'hd0, 8'he0};
	int bad_count = 0, tests_run = 0, cyc = 0, i;
	spis_top i_dut (.*);
	spis_shifter_model i_far (.i_clk_sys, .i_rst_n, .i_stall(stall), .i_valid(o_shift_valid),
		.i_data(o_shift_data), .o_ready(i_shift_ready), .o_done(i_shift_done),
		.o_last(last), .o_count(cnt));
	// Free-running system clock.
	initial forever #4 i_clk_sys = ~i_clk_sys;
	task end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// A hang is cut short well beyond the few hundred cycles the run needs.
	always @(posedge i_clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			end_sim;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Read data already stands in the access phase and is taken at the ready edge.
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk_sys);
		i_penable <= 1;
		@(posedge i_clk_sys);
		while (o_pready !== 1'b1) @(posedge i_clk_sys);
		rd = o_prdata;
		i_psel <= 0;
		i_penable <= 0;
	endtask
	// One received char; the data line shows junk once the char has gone.
	task rxc(input logic [3:0] f, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_rx_char_valid <= 1;
		{i_rx_break, i_rx_framing, i_rx_parity, i_rx_wakeup} <= f;
		i_rx_char_data <= d;
		@(posedge i_clk_sys);
		i_rx_char_valid <= 0;
		{i_rx_break, i_rx_framing, i_rx_parity, i_rx_wakeup} <= 4'h0;
		i_rx_char_data <= ~d;
	endtask
	// Main sequence.
	initial
	begin
		repeat (6) @(posedge i_clk_sys);
		i_rst_n <= 1;
		apb(0, SPIS_TX_ADDR, 0);
		chk(rd & 32'hc1, 32'hc0);
		apb(0, SPIS_RX_ADDR, 0);
		chk(rd, 0);
		apb(0, 16'h00f0, 0);
		chk(rd, 0);
		apb(1, SPIS_CTL_ADDR, 1);
		apb(1, SPIS_TX_ADDR, 1);
		apb(0, SPIS_TX_ADDR, 0);
		chk(rd & 32'hc1, 32'hc1);
		chk(32'(o_tx_irq_req), 1);
		for (i = 0; i < 33; i++) apb(1, SPIS_TXDATA_ADDR, i);
		apb(0, SPIS_TX_ADDR, 0);
		chk(rd & 32'hc1, 32'h01);
		chk(32'(o_tx_irq_req), 0);
		stall <= 0;
		i = 0;
		do apb(0, SPIS_TX_ADDR, 0); while (rd[6] !== 1'b1 && ++i < 300);
		chk(rd & 32'hc1, 32'hc1);
		chk(32'(cnt), 32);
		chk(32'(last), 31);
		for (i = 0; i < 4; i++)
		begin
			rxc(4'(1 << i), 8'(i));
			apb(0, SPIS_RX_ADDR, 0);
			chk(rd, 32'(ex[i]));
			chk(32'(o_rx_irq_req), 0);
			apb(0, SPIS_RXDATA_ADDR, 0);
			chk(rd & 32'hff, i);
			apb(0, SPIS_RX_ADDR, 0);
			chk(rd, 0);
		end
		apb(1, SPIS_RX_ADDR, 1);
		rxc(4'h0, 8'h11);
		apb(0, SPIS_RX_ADDR, 0);
		chk(rd, 32'h41);
		chk(32'(o_rx_irq_req), 1);
		rxc(4'h0, 8'h22);
		apb(0, SPIS_RX_ADDR, 0);
		chk(rd, 32'hc9);
		apb(0, SPIS_RXDATA_ADDR, 0);
		chk(rd & 32'hff, 32'h22);
		stall <= 1;
		rxc(4'h0, 8'h33);
		apb(1, SPIS_TXDATA_ADDR, 5);
		apb(1, SPIS_CTL_ADDR, 0);
		apb(0, SPIS_RX_ADDR, 0);
		chk(rd, 1);
		apb(0, SPIS_TX_ADDR, 0);
		chk(rd & 32'hc1, 32'hc1);
		i_rst_n <= 0;
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1;
		apb(0, SPIS_TX_ADDR, 0);
		chk(rd & 32'hc1, 32'hc0);
		end_sim;
	end
endmodule
`default_nettype wire
